// file: logic/pm_regs.sv
// power-management control, status, bridge extension and data registers
`timescale 1ns/1ps
module pm_regs
	import pm_regs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire cfg_req_t    cfg_req,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_ack,
	input  wire logic        wake_event,
	input  wire logic        newer_pm_support_enable,
	output logic             wake_out_n,
	output logic             internal_reset,
	output bus_ctrl_t        bus_ctrl,
	output logic [1:0]       power_state
);

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address and byte decoding
	function automatic logic lane_hit(input cfg_req_t r, input logic [7:0] ofs);
		lane_hit = r.wr && (r.addr[7:2] == ofs[7:2]) && r.byte_en[ofs[1:0]];
	endfunction : lane_hit

	wire logic        dword_hit = (cfg_req.addr[7:2] == OFS_DWORD_BASE[7:2]);
	wire logic        cap_hit   = (cfg_req.addr[7:2] == OFS_CAP_WORD[7:2]);
	wire logic        wr_lo     = lane_hit(cfg_req, OFS_CTRL_STATUS);
	wire logic        wr_hi     = lane_hit(cfg_req, OFS_CTRL_STATUS + 8'h01);
	wire logic        wr_ext    = lane_hit(cfg_req, OFS_BRIDGE_EXT);
	wire logic [15:0] wr_half   = cfg_req.wdata[15:0];
	wire logic [7:0]  wr_ext_b  = cfg_req.wdata[23:16];

	////////////////////////////////////////////////////////////////////////
	// stored bits; the internal reset never touches these, only reset_n
	logic [1:0] state_q;
	logic [1:0] state_d;
	logic       wake_en_q;
	logic       wake_en_d;
	logic       wake_stat_q;
	logic       wake_stat_d;
	logic       action_sel_q;
	logic       action_sel_d;
	logic       int_rst_q;

	wire logic  bpcc_enable = BRIDGE_RESET[BIT_BUS_POWER_CLOCK_CTRL_ENABLE];      // fixed one

	// next values
	assign state_d      = wr_lo ? wr_half[1:0] : state_q;
	assign wake_en_d    = wr_hi ? wr_half[BIT_WAKE_ENABLE] : wake_en_q;
	// set beats clear so a coincident event is never lost
	assign wake_stat_d  = wake_event
	                    | (wake_stat_q
	                       & ~(wr_hi & wr_half[BIT_WAKE_STATUS]));
	assign action_sel_d = wr_ext ? wr_ext_b[BIT_ACTION_SEL] : action_sel_q;

	always_ff @(posedge clk_sys or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			state_q      <= CTRL_RESET[1:0];
			wake_en_q    <= CTRL_RESET[BIT_WAKE_ENABLE];
			wake_stat_q  <= CTRL_RESET[BIT_WAKE_STATUS];
			action_sel_q <= BRIDGE_RESET[BIT_ACTION_SEL];
			int_rst_q    <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			wake_en_q    <= wake_en_d;
			wake_stat_q  <= wake_stat_d;
			action_sel_q <= action_sel_d;
			// one-cycle pulse for the other bridge registers
			int_rst_q    <= (state_q == STATE_D3HOT) && (state_d == STATE_D0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign wake_out_n     = ~(wake_stat_q & wake_en_q);
	assign internal_reset = int_rst_q;
	assign power_state    = state_q;
	// without bus control the state field does not steer the bus
	wire logic d3hot_steer = bpcc_enable && (state_q == STATE_D3HOT);
	assign bus_ctrl = {d3hot_steer && action_sel_q,                // clock stop
	                   d3hot_steer && !action_sel_q};              // power off

	////////////////////////////////////////////////////////////////////////
	// read data: unused fields are constant zero
	wire logic [15:0] ctrl_word = {wake_stat_q, 6'h00, wake_en_q,
	                               6'h00, state_q};
	wire logic [7:0]  ext_byte  = {bpcc_enable, action_sel_q, 6'h00};
	wire logic [2:0]  version   = newer_pm_support_enable ? VERSION_NEW
	                                                      : VERSION_OLD;
	wire logic [31:0] rd_mux    = dword_hit ? {POWER_DATA_VAL, ext_byte, ctrl_word}
	                            : cap_hit   ? {CAP_UPPER_BITS, version, 16'h0000}
	                            : 32'h0000_0000;
	logic [31:0] rdata_q;
	logic        ack_q;

	always_ff @(posedge clk_sys or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= cfg_req.rd ? rd_mux : rdata_q;
			ack_q   <= cfg_req.rd | cfg_req.wr;
		end
	end

	assign cfg_rdata = rdata_q;
	assign cfg_ack   = ack_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_stat_write_one;
		wr_hi && wr_half[BIT_WAKE_STATUS] && !wake_event;
	endsequence

	property p_status_sets;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		wake_event |=> wake_stat_q;
	endproperty
	a_status_sets: assert property (p_status_sets) else $error("status not set");

	property p_status_clears;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_stat_write_one |=> !wake_stat_q ##0 wake_out_n;
	endproperty
	a_status_clears: assert property (p_status_clears) else $error("status not cleared");

	property p_zero_keeps;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(wr_hi && !wr_half[BIT_WAKE_STATUS] && wake_stat_q) |=> wake_stat_q;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed status");

	property p_wake_gate;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(wr_hi && !wr_half[BIT_WAKE_ENABLE]) |=> wake_out_n;
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake without enable");

	property p_state_write;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		wr_lo |=> power_state == $past(wr_half[1:0]);
	endproperty
	a_state_write: assert property (p_state_write) else $error("state not stored");

	property p_int_reset;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(state_q == STATE_D3HOT && wr_lo && wr_half[1:0] == STATE_D0)
		|=> internal_reset ##1 !internal_reset;
	endproperty
	a_int_reset: assert property (p_int_reset) else $error("internal reset missing");

	property p_keep_through;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(internal_reset && !wr_hi && !wake_event) |=> $stable(wake_en_q);
	endproperty
	a_keep_through: assert property (p_keep_through) else $error("lost value");

	property p_read_zero;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(cfg_req.rd && dword_hit) |=> (cfg_rdata[31:24] == 8'h00
		                              && cfg_rdata[14:9] == 6'h00
		                              && cfg_rdata[7:2] == 6'h00
		                              && cfg_rdata[23] && cfg_rdata[21:16] == 6'h00);
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("fixed bits wrong");

	property p_bus_action;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(power_state == STATE_D3HOT) |-> (bus_ctrl.clock_stop == action_sel_q)
		                                 && (bus_ctrl.power_off != action_sel_q);
	endproperty
	a_bus_action: assert property (p_bus_action) else $error("bus action wrong");

	// steps of the D3hot exit: a quiet state write, then a one-cycle pulse
	sequence s_d3hot_exit;
		(state_q == STATE_D3HOT) && wr_lo && (wr_half[1:0] == STATE_D0)
		&& !wr_hi && !wr_ext && !wake_event;
	endsequence

	sequence s_reset_pulse;
		internal_reset ##1 !internal_reset;
	endsequence

	sequence s_dword_read;
		cfg_req.rd && dword_hit;
	endsequence

	sequence s_cap_read;
		cfg_req.rd && cap_hit;
	endsequence

	// an event with enable on pulls the wake line in the next cycle
	property p_wake_raise;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(wake_event && wake_en_q && !wr_hi) |=> !wake_out_n;
	endproperty
	a_wake_raise: assert property (p_wake_raise) else $error("wake not raised");

	// only a write to the enable/status byte can let the wake line go
	property p_wake_hold;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(!wake_out_n && !wr_hi) |=> !wake_out_n;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake dropped early");

	// enable bit follows its lane
	property p_en_write;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		wr_hi |=> (wake_en_q == $past(wr_half[BIT_WAKE_ENABLE]));
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable not stored");

	// status never sets without an event
	property p_status_source;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(!wake_stat_q && !wake_event) |=> !wake_stat_q;
	endproperty
	a_status_source: assert property (p_status_source) else $error("status set alone");

	// writes to other lanes leave the status alone
	property p_status_other_lanes;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(wake_stat_q && !wr_hi) |=> wake_stat_q;
	endproperty
	a_status_other_lanes: assert property (p_status_other_lanes) else $error("status lost");

	// state only moves on a write to its lane
	property p_state_keep;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		!wr_lo |=> $stable(state_q);
	endproperty
	a_state_keep: assert property (p_state_keep) else $error("state moved");

	// read data shows the stored fields of the taking cycle
	property p_state_read;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_dword_read |=> (cfg_rdata[1:0] == $past(state_q));
	endproperty
	a_state_read: assert property (p_state_read) else $error("state read wrong");

	property p_flag_read;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_dword_read |=> (cfg_rdata[15] == $past(wake_stat_q))
		                 && (cfg_rdata[8] == $past(wake_en_q));
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("wake bits read wrong");

	property p_ext_read;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_dword_read |=> cfg_rdata[23] && (cfg_rdata[22] == $past(action_sel_q));
	endproperty
	a_ext_read: assert property (p_ext_read) else $error("bridge byte read wrong");

	property p_data_read;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_dword_read |=> (cfg_rdata[31:24] == POWER_DATA_VAL);
	endproperty
	a_data_read: assert property (p_data_read) else $error("data byte not zero");

	// version follows the newer-support input
	property p_cap_read;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_cap_read |=> (cfg_rdata[31:19] == CAP_UPPER_BITS)
		               && (cfg_rdata[18:16] == ($past(newer_pm_support_enable)
		                                        ? VERSION_NEW : VERSION_OLD));
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("version read wrong");

	// action select follows its lane
	property p_action_write;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		wr_ext |=> (action_sel_q == $past(wr_ext_b[BIT_ACTION_SEL]));
	endproperty
	a_action_write: assert property (p_action_write) else $error("select not stored");

	// outside D3hot the secondary bus is left running
	property p_bus_idle;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		(power_state != STATE_D3HOT) |-> !bus_ctrl.clock_stop && !bus_ctrl.power_off;
	endproperty
	a_bus_idle: assert property (p_bus_idle) else $error("bus steered outside D3hot");

	// the pulse has no other cause than the D3hot exit
	property p_int_cause;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		internal_reset |-> ($past(state_q) == STATE_D3HOT) && (state_q == STATE_D0);
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("spurious internal reset");

	property p_int_pulse;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_d3hot_exit |=> s_reset_pulse;
	endproperty
	a_int_pulse: assert property (p_int_pulse) else $error("internal reset not a pulse");

	// power-management bits ride through the internal reset
	property p_keep_regs;
		@(posedge clk_sys) disable iff (!rst_sync_q)
		s_d3hot_exit |=> (wake_en_q == $past(wake_en_q))
		                 && (wake_stat_q == $past(wake_stat_q))
		                 && (action_sel_q == $past(action_sel_q));
	endproperty
	a_keep_regs: assert property (p_keep_regs) else $error("bits lost at D3hot exit");

endmodule : pm_regs

// file: logic/pm_regs_pkg.sv
// constants and carriers for the cardbus power-management register bank
package pm_regs_pkg;

	localparam logic [7:0]  OFS_CTRL_STATUS = 8'ha4;
	localparam logic [7:0]  OFS_DWORD_BASE  = 8'ha4;
	localparam logic [7:0]  OFS_BRIDGE_EXT  = 8'ha6;
	localparam logic [7:0]  OFS_POWER_DATA  = 8'ha7;
	localparam logic [7:0]  OFS_CAP_WORD    = 8'ha0;

	localparam int          BIT_WAKE_STATUS = 15;
	localparam int          BIT_WAKE_ENABLE = 8;
	localparam int          BIT_ACTION_SEL  = 6;
	localparam int          BIT_BUS_POWER_CLOCK_CTRL_ENABLE     = 7;

	localparam logic [1:0]  STATE_D0        = 2'h0;
	localparam logic [1:0]  STATE_D3HOT     = 2'h3;

	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [7:0]  BRIDGE_RESET    = 8'hc0;
	localparam logic [7:0]  POWER_DATA_VAL  = 8'h00;
	localparam logic [2:0]  VERSION_OLD     = 3'h1;
	localparam logic [2:0]  VERSION_NEW     = 3'h2;
	localparam logic [12:0] CAP_UPPER_BITS  = 13'h1fc6;

	// one configuration access from the host side
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} cfg_req_t;

	// what the secondary bus should do
	typedef struct packed {
		logic clock_stop;
		logic power_off;
	} bus_ctrl_t;

endpackage : pm_regs_pkg

// file: bench/cfg_host_model.sv
// host-side model issuing configuration reads and writes
`timescale 1ns/1ps
module cfg_host_model
	import pm_regs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata,
	output cfg_req_t         cfg_req
);
	// idle, no request before the bench asks
	initial cfg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, byte_en: 4'h0, wdata: 32'h0};
	// one access, held across the taking edge; stale qualifiers scrambled after
	task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic ack);
		@(posedge clk_sys) #1;
		cfg_req = '{rd: ~wr, wr: wr, addr: addr, byte_en: be, wdata: wd};
		@(posedge clk_sys) #1;
		ack = cfg_ack;
		rd = cfg_rdata;
		cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, byte_en: ~be, wdata: ~wd};
	endtask : access
endmodule : cfg_host_model

// file: bench/cardbus_power_mgmt_regs_test.sv
// self-checking bench for the power-management register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	compares++; \
	if ((got) !== (exp)) \
	begin \
		bad_count++; \
		$display("ERROR %s expected %h seen %h", nm, exp, got); \
	end
module cardbus_power_mgmt_regs_test;
	import pm_regs_pkg::*;
	logic        clk_sys, reset_n, cfg_ack, wake_event, newer, wake_out_n, internal_reset, ack;
	cfg_req_t    cfg_req;
	bus_ctrl_t   bus_ctrl;
	logic [31:0] cfg_rdata, rd, seed;
	logic [1:0]  power_state;
	int          bad_count, compares, m_state, m_en, m_st, m_act;
	//////////////////////////////////////////////////////////////////////////////
	pm_regs pm_regs_inst (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wake_event(wake_event),
		.newer_pm_support_enable(newer), .wake_out_n(wake_out_n),
		.internal_reset(internal_reset), .bus_ctrl(bus_ctrl), .power_state(power_state));
	cfg_host_model cfg_host_model_inst (.clk_sys(clk_sys), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .cfg_req(cfg_req));
	// 25 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic report_and_stop();
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// read the dword back and compare every visible output except internal_reset with the model
	task automatic check_all();
		logic [31:0] e;
		e = {8'h00, 1'b1, m_act[0], 6'h00, m_st[0], 6'h00, m_en[0], 6'h00, m_state[1:0]};
		cfg_host_model_inst.access(1'b0, OFS_CTRL_STATUS, 4'hf, 32'h0, rd, ack);
		`CHK("ack", 1'b1, ack)
		`CHK("dword", e, rd)
		`CHK("state", m_state[1:0], power_state)
		`CHK("bus", ({m_act[0], ~m_act[0]} & {2{m_state == 3}}), bus_ctrl)
		`CHK("wake", ~(m_st[0] & m_en[0]), wake_out_n)
	endtask : check_all
	// write, update the model, then compare; ram-style lanes at the one dword
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		int old;
		old = m_state;
		cfg_host_model_inst.access(1'b1, a, be, d, rd, ack);
		if (a[7:2] == OFS_DWORD_BASE[7:2])
		begin
			if (be[0])
				m_state = int'(d[1:0]);
			if (be[1])
				m_en = int'(d[8]);
			if (be[1] && d[15])
				m_st = 0;
			if (be[2])
				m_act = int'(d[22]);
		end
		if (wake_event)
			m_st = 1; // set wins over clear
		`CHK("ireset", (old == 3 && m_state == 0), internal_reset)
		check_all();
	endtask : wr
	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{reset_n, wake_event, newer, m_state, m_en, m_st} = '0;
		m_act = 1;
		seed = 32'h0000_b018;
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		check_all();
		for (int v = 0; v < 2; v++)
		begin
			newer = v[0];
			cfg_host_model_inst.access(1'b0, OFS_CAP_WORD, 4'hf, 32'h0, rd, ack);
			`CHK("cap", ({CAP_UPPER_BITS, v ? 3'h2 : 3'h1, 16'h0000}), rd)
		end
		cfg_host_model_inst.access(1'b0, 8'h40, 4'hf, 32'h0, rd, ack);
		`CHK("unmapped", 32'h0, rd)
		$display("test reset and read-only values done");
		// wake raised while disabled, then enabled, zero write, one write
		@(posedge clk_sys) #1 wake_event = 1'b1;
		@(posedge clk_sys) #1 wake_event = 1'b0;
		m_st = 1;
		check_all();
		wr(OFS_CTRL_STATUS, 4'h2, 32'h0000_0100);
		wr(OFS_CTRL_STATUS, 4'h2, 32'h0000_7f00);
		wr(OFS_CTRL_STATUS, 4'h2, 32'h0000_8100);
		$display("test wake status done");
		wr(OFS_CTRL_STATUS, 4'h1, 32'h0000_0003);
		wr(OFS_CTRL_STATUS, 4'h4, 32'h0000_0000);
		wr(OFS_CTRL_STATUS, 4'h1, 32'h0000_0000);
		$display("test power states done");
		repeat (40)
		begin
			seed = xs(seed);
			@(posedge clk_sys) #1 wake_event = seed[9];
			wr(seed[31] ? OFS_CAP_WORD : OFS_CTRL_STATUS, seed[7:4], seed);
		end
		$display("test random writes done");
		report_and_stop();
	end
	// watchdog, far beyond the expected run
	initial
	begin
		#400000;
		bad_count++;
		report_and_stop();
	end
endmodule : cardbus_power_mgmt_regs_test
